// File: reo_top.sv
`timescale 1ns/100ps
// What this block does
// - device answers at bus address 0x25
// - pin one drives second step-down, load switch
// - pin two drives both linear rails
// - pin three drives third step-down rail
// - pin four drives first step-down rail
// - cycle enable bit permits power cycle
// - shutdown enable plus 6 s press: off
// - shutdown disabled: long press ignored
// - third step-down: 0.8V base, 12.5mV steps
// - first option linear: 0.8V, 12.5mV
// - second option first step-down: 0.6V, 9.376mV
// - second option linear: 0.6V, 9.376mV
// - second option second step-down: 0.8V, 12.5mV
module reo_top
    import reo_pkg::*;
#(
    parameter logic [31:0] LONG_PRESS_CYC = REO_LONG_PRESS_CYC
)
(
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic        general_pin_one,
    input  wire logic        general_pin_two,
    input  wire logic        general_pin_three,
    input  wire logic        general_pin_four,
    input  wire logic        pushbutton_input_n,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    output logic             step_down_rail_first,
    output logic             step_down_rail_second,
    output logic             step_down_rail_third,
    output logic             linear_rail_first,
    output logic             linear_rail_second,
    output logic             load_switch_gate,
    output logic             power_off,
    output logic             power_cycle_allowed
);
    // synchronised levels travel in an interface, so the input
    // stage can grow without touching this port list
    reo_sync_if sync ();           // synchronised pin levels

    // register state, reset by nrst alone
    // codes are clamped on the way in, so a read
    // shows what the rail is really set to
    logic [7:0]  ctrl_reg;         // enables and option; wake is not stored
    logic [7:0]  vcode_b1_reg;     // voltage codes per rail
    logic [7:0]  vcode_b2_reg;
    logic [7:0]  vcode_b3_reg;
    logic [7:0]  vcode_ldo_reg;
    logic [31:0] rdata_reg;        // read data, one cycle after strobe
    // six seconds at 25 MHz need 28 bits; 32 leave
    // room for a slower long press setting
    logic [31:0] press_cnt_reg;    // long press counter
    logic [31:0] press_cnt_next;
    // one-hot power state, only two states
    reo_state_e  state_reg;        // power on / power off
    reo_state_e  state_next;
    logic [5:0]  rails_reg;        // registered rail enables

    // control field decode and the synchronised button
    // wake_write looks at the bus, bit three is never stored
    // press_long holds while the press lasts, as the count saturates
    // pressed is the button after both flops, active high here
    wire logic cycle_en    = ctrl_reg[REO_CTRL_CYCLE_BIT];
    wire logic shdn_en     = ctrl_reg[REO_CTRL_SHDN_BIT];
    wire logic option_sel  = ctrl_reg[REO_CTRL_OPTION_BIT];
    wire logic wake_write  = reg_wr && (reg_addr == REO_OFS_CTRL)
                             && reg_wdata[REO_CTRL_WAKE_BIT];
    wire logic pressed     = !sync.button_n;
    wire logic press_long  = (press_cnt_reg >= LONG_PRESS_CYC);

    // base and step selection per rail, in microvolts
    // only the first step-down rail and the linear pair
    // change scale with the option bit; the second and
    // third step-down rails keep the coarse scale
    // constants picked by one bit, so no flop is needed
    // microvolt units keep the fine step exact
    wire logic [31:0] base_b1  = (option_sel == REO_OPT_EXT) ? REO_BASE_06_UV
                                                           : REO_BASE_08_UV;
    wire logic [31:0] step_b1  = (option_sel == REO_OPT_EXT) ? REO_STEP_9376_UV
                                                           : REO_STEP_125_UV;
    wire logic [31:0] base_b2  = REO_BASE_08_UV;
    wire logic [31:0] step_b2  = REO_STEP_125_UV;
    wire logic [31:0] base_b3  = REO_BASE_08_UV;
    wire logic [31:0] step_b3  = REO_STEP_125_UV;
    wire logic [31:0] base_ldo = (option_sel == REO_OPT_EXT) ? REO_BASE_06_UV
                                                           : REO_BASE_08_UV;
    wire logic [31:0] step_ldo = (option_sel == REO_OPT_EXT) ? REO_STEP_9376_UV
                                                           : REO_STEP_125_UV;

    // top code limit: codes past the top setting are clamped
    // the limit follows the scale constants, so a new base
    // or step moves the clamp point with it
    // with the present scales every 8-bit code is legal;
    // the clamp guards a later, narrower range
    // the division is on constants only, no divider remains
    function automatic logic [7:0] clamp_code(input logic [7:0] code,
                                              input logic [31:0] base,
                                              input logic [31:0] step,
                                              input logic [31:0] top);
        logic [31:0] lim;
        lim = (top - base) / step;
        if ({24'h000000, code} > lim)
            clamp_code = lim[7:0];
        else
            clamp_code = code;
    endfunction

    // top settings follow the same option choice
    wire logic [31:0] top_b1  = (option_sel == REO_OPT_EXT) ? REO_TOP_2991_UV
                                                          : REO_TOP_3998_UV;
    wire logic [31:0] top_ldo = (option_sel == REO_OPT_EXT) ? REO_TOP_2991_UV
                                                          : REO_TOP_3998_UV;
    // low byte, all that a code register keeps
    wire logic [7:0] wcode = reg_wdata[7:0];

    // synchroniser for the pins and the button
    // the pins come from a processor unrelated to sys_clk;
    // nothing reads them before two flops, which costs two
    // cycles on every enable but keeps the rails clean
    // flop reset values read as pins low, button up
    reo_sync u_sync (
        .sys_clk        (sys_clk),
        .nrst           (nrst),
        .pins_async     ({general_pin_four, general_pin_three,
                          general_pin_two, general_pin_one}),
        .button_async_n (pushbutton_input_n),
        .sync           (sync)
    );

    // control and voltage code registers; code writes are clamped to range
    // one strobe, one register; read-only offsets fall
    // through to the default branch and change nothing
    // a write lands at its edge, a read sees it next cycle
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_reg      <= REO_CTRL_RESET;
            vcode_b1_reg  <= REO_VCODE_RESET;
            vcode_b2_reg  <= REO_VCODE_RESET;
            vcode_b3_reg  <= REO_VCODE_RESET;
            vcode_ldo_reg <= REO_VCODE_RESET;
        end else if (reg_wr) begin
            case (reg_addr)
                REO_OFS_CTRL: begin
                    // enables and option; wake is not stored
                    ctrl_reg <= {5'h00, reg_wdata[REO_CTRL_OPTION_BIT:0]};
                end
                REO_OFS_VCODE_B1: begin
                    // scale follows the option bit
                    vcode_b1_reg <= clamp_code(wcode, base_b1, step_b1, top_b1);
                end
                REO_OFS_VCODE_B2: begin
                    // coarse scale in both options
                    vcode_b2_reg <= clamp_code(wcode, base_b2, step_b2,
                                               REO_TOP_3998_UV);
                end
                REO_OFS_VCODE_B3: begin
                    // coarse scale in both options
                    vcode_b3_reg <= clamp_code(wcode, base_b3, step_b3,
                                               REO_TOP_3998_UV);
                end
                REO_OFS_VCODE_LDO: begin
                    // the linear pair share one code
                    vcode_ldo_reg <= clamp_code(wcode, base_ldo, step_ldo, top_ldo);
                end
                default: begin
                    // read-only or unmapped: write ignored
                end
            endcase
        end
    end

    // long press counter; only runs while shutdown is enabled
    // a release restarts it, so short presses never add up
    // it stops at the limit; a wrap would drop press_long
    // in the middle of a long hold
    // clearing the shutdown enable clears the count at once
    always_comb begin
        press_cnt_next = press_cnt_reg;
        if (!pressed || !shdn_en)
            press_cnt_next = 32'h0;
        else if (!press_long)
            press_cnt_next = press_cnt_reg + 32'h1;
    end

    // power state: long press turns off, a wake write brings it back
    // only software leaves the off state; waking with the
    // button held would let the same press turn it off again
    // the wake write needs the button seen up through both flops
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            REO_ST_ON: begin
                // only an enabled long press ends the on state
                if (shdn_en && press_long)
                    state_next = REO_ST_OFF;
            end
            REO_ST_OFF: begin
                // rails stay gated until software wakes the device
                if (wake_write && !pressed)
                    state_next = REO_ST_ON;
            end
            default: begin
                // a code that is not one-hot falls back to on
                state_next = REO_ST_ON;
            end
        endcase
    end

    // pin levels map straight to rails, no internal sequence
    // the outside processor owns all ordering, so there is
    // no delay or sequence table; each pin gates its group
    // the option bit plays no part in this gating
    // bit five, the load switch, is listed first
    wire logic [5:0] rails_direct = {
        sync.pin_level[0],      // load switch
        sync.pin_level[1],      // linear second
        sync.pin_level[1],      // linear first
        sync.pin_level[2],      // step-down 3
        sync.pin_level[0],      // step-down 2
        sync.pin_level[3]       // step-down 1
    };
    // the state gates every rail at once, none can lag
    wire logic rails_live = (state_reg == REO_ST_ON);

    // state, counter and rail enable flops
    // the rail image is registered so the pins never glitch
    // going off gates the image one edge after the state
    // a rail follows its pin three edges late: two sync, one here
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg     <= REO_ST_ON;
            press_cnt_reg <= 32'h0;
            rails_reg     <= 6'h00;
        end else begin
            state_reg     <= state_next;
            press_cnt_reg <= press_cnt_next;
            rails_reg     <= rails_live ? rails_direct : 6'h00;
        end
    end

    // rail pins, one bit of the rail image each
    assign step_down_rail_first  = rails_reg[0];
    assign step_down_rail_second = rails_reg[1];
    assign step_down_rail_third  = rails_reg[2];
    assign linear_rail_first     = rails_reg[3];
    assign linear_rail_second    = rails_reg[4];
    assign load_switch_gate      = rails_reg[5];
    // off flag straight from the state register
    assign power_off             = (state_reg == REO_ST_OFF);
    // cycle enable passed out as a plain level
    assign power_cycle_allowed   = cycle_en;

    // read mux; unmapped addresses read zero
    // status mirrors the rail image, so software sees
    // what the pins switched; base and step are constants
    wire logic [31:0] status_word = {24'h000000, press_long, power_off,
                                     rails_reg};
    logic [31:0] rmux;
    always_comb begin
        case (reg_addr)
            REO_OFS_CTRL:      rmux = {24'h000000, ctrl_reg};
            REO_OFS_STATUS:    rmux = status_word;
            REO_OFS_VCODE_B1:  rmux = {24'h000000, vcode_b1_reg};
            REO_OFS_VCODE_B2:  rmux = {24'h000000, vcode_b2_reg};
            REO_OFS_VCODE_B3:  rmux = {24'h000000, vcode_b3_reg};
            REO_OFS_VCODE_LDO: rmux = {24'h000000, vcode_ldo_reg};
            REO_OFS_VBASE_B1:  rmux = base_b1;
            REO_OFS_VBASE_B2:  rmux = base_b2;
            REO_OFS_VBASE_B3:  rmux = base_b3;
            REO_OFS_VBASE_LDO: rmux = base_ldo;
            REO_OFS_VSTEP_B1:  rmux = step_b1;
            REO_OFS_VSTEP_B2:  rmux = step_b2;
            REO_OFS_VSTEP_B3:  rmux = step_b3;
            REO_OFS_VSTEP_LDO: rmux = step_ldo;
            // 7-bit address low, read byte above it
            REO_OFS_ADDR:      rmux = {16'h0000, REO_BUS_RD_BYTE, 1'b0, REO_BUS_ADDR};
            default:           rmux = 32'h0;
        endcase
    end

    // read data registered, valid only the cycle after the strobe
    // zero outside the answer, so a stale word cannot pass
    // for a fresh one
    // the mux settles within the strobe cycle
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst)
            rdata_reg <= 32'h0;
        else
            rdata_reg <= reg_rd ? rmux : 32'h0;
    end

    // read data leave straight from the flop
    assign reg_rdata = rdata_reg;
endmodule

// File: reo_pkg.sv
package reo_pkg;
    // control bus target address and address bytes
    localparam logic [6:0] REO_BUS_ADDR      = 7'h25;
    localparam logic [7:0] REO_BUS_WR_BYTE   = 8'h4a;
    localparam logic [7:0] REO_BUS_RD_BYTE   = 8'h4b;

    // register offsets of the plain register port
    localparam logic [3:0] REO_OFS_CTRL      = 4'h0;
    localparam logic [3:0] REO_OFS_STATUS    = 4'h1;
    localparam logic [3:0] REO_OFS_VCODE_B1  = 4'h2;
    localparam logic [3:0] REO_OFS_VCODE_B2  = 4'h3;
    localparam logic [3:0] REO_OFS_VCODE_B3  = 4'h4;
    localparam logic [3:0] REO_OFS_VCODE_LDO = 4'h5;
    localparam logic [3:0] REO_OFS_VBASE_B1  = 4'h6;
    localparam logic [3:0] REO_OFS_VBASE_B2  = 4'h7;
    localparam logic [3:0] REO_OFS_VBASE_B3  = 4'h8;
    localparam logic [3:0] REO_OFS_VBASE_LDO = 4'h9;
    localparam logic [3:0] REO_OFS_VSTEP_B1  = 4'ha;
    localparam logic [3:0] REO_OFS_VSTEP_B2  = 4'hb;
    localparam logic [3:0] REO_OFS_VSTEP_B3  = 4'hc;
    localparam logic [3:0] REO_OFS_VSTEP_LDO = 4'hd;
    localparam logic [3:0] REO_OFS_ADDR      = 4'he;

    // control register fields
    localparam int REO_CTRL_CYCLE_BIT    = 0;
    localparam int REO_CTRL_SHDN_BIT     = 1;
    localparam int REO_CTRL_OPTION_BIT   = 2;
    localparam int REO_CTRL_WAKE_BIT     = 3;
    localparam logic [7:0] REO_CTRL_RESET = 8'h01;

    // option select: 0 = sequencer option, 1 = external processor option
    localparam logic REO_OPT_SEQ = 1'b0;
    localparam logic REO_OPT_EXT = 1'b1;

    // voltage code width and reset code
    localparam int REO_VCODE_W = 8;
    localparam logic [7:0] REO_VCODE_RESET = 8'h00;
    localparam logic [7:0] REO_VCODE_MAX   = 8'hff;

    // voltage base and step in microvolts
    localparam logic [31:0] REO_BASE_08_UV  = 32'd800000;
    localparam logic [31:0] REO_BASE_06_UV  = 32'd600000;
    localparam logic [31:0] REO_STEP_125_UV = 32'd12500;
    localparam logic [31:0] REO_STEP_9376_UV = 32'd9376;
    localparam logic [31:0] REO_TOP_3998_UV = 32'd3998000;
    localparam logic [31:0] REO_TOP_2991_UV = 32'd2991000;

    // long press timing
    localparam int REO_CLK_HZ         = 25000000;
    localparam int REO_LONG_PRESS_S   = 6;
    localparam logic [31:0] REO_LONG_PRESS_CYC = 32'(REO_CLK_HZ * REO_LONG_PRESS_S);

    // power state
    typedef enum logic [1:0] {
        REO_ST_ON  = 2'b01,
        REO_ST_OFF = 2'b10
    } reo_state_e;
endpackage

// File: reo_sync_if.sv
`timescale 1ns/100ps
// synchronised pin levels handed from the input stage to the main logic
interface reo_sync_if;
    logic [3:0] pin_level;   // rail group enables, synchronised
    logic       button_n;    // pushbutton, synchronised, active low
    modport src (output pin_level, output button_n);
    modport dst (input pin_level, input button_n);
endinterface

// File: reo_sync.sv
`timescale 1ns/100ps
// two flop synchroniser for the four group pins and the pushbutton
module reo_sync
    import reo_pkg::*;
(
    input  wire logic   sys_clk,
    input  wire logic   nrst,
    input  wire logic [3:0] pins_async,
    input  wire logic   button_async_n,
    reo_sync_if.src     sync
);
    logic [4:0] stage1_reg;   // first stage, read only by stage two
    logic [4:0] stage2_reg;   // second stage, safe to use

    // both stages reset to pins low, button released
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            stage1_reg <= 5'h10;
            stage2_reg <= 5'h10;
        end else begin
            stage1_reg <= {button_async_n, pins_async};
            stage2_reg <= stage1_reg;
        end
    end

    assign sync.pin_level = stage2_reg[3:0];
    assign sync.button_n  = stage2_reg[4];
endmodule

// File: reo_top_props.sv
`timescale 1ns/100ps
// watches the top ports only; rail timing is two sync flops plus the output flop
module reo_top_props
    import reo_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        nrst,
    input wire logic        general_pin_one,
    input wire logic        general_pin_two,
    input wire logic        general_pin_three,
    input wire logic        general_pin_four,
    input wire logic        pushbutton_input_n,
    input wire logic [3:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        step_down_rail_first,
    input wire logic        step_down_rail_second,
    input wire logic        step_down_rail_third,
    input wire logic        linear_rail_first,
    input wire logic        linear_rail_second,
    input wire logic        load_switch_gate,
    input wire logic        power_off,
    input wire logic        power_cycle_allowed
);
    logic [2:0] since_rst_reg;   // edges since release, saturates so history is clean
    // count edges after reset so the three cycle history never reaches into reset
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) since_rst_reg <= 3'h0;
        else if (since_rst_reg != 3'h7) since_rst_reg <= since_rst_reg + 3'h1;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    a_rail_first_follow: assert property (since_rst_reg >= 3'h3 |->
        step_down_rail_first == ($past(general_pin_four, 3) && !$past(power_off)))
        else $error("first step-down rail does not follow pin four");
    a_rail_second_pair: assert property (since_rst_reg >= 3'h3 |->
        step_down_rail_second == ($past(general_pin_one, 3) && !$past(power_off))
        && load_switch_gate == step_down_rail_second)
        else $error("second step-down rail or load switch wrong");
    a_linear_pair: assert property (since_rst_reg >= 3'h3 |->
        linear_rail_first == ($past(general_pin_two, 3) && !$past(power_off))
        && linear_rail_second == linear_rail_first)
        else $error("linear rails do not follow pin two");
    a_rail_third_follow: assert property (since_rst_reg >= 3'h3 |->
        step_down_rail_third == ($past(general_pin_three, 3) && !$past(power_off)))
        else $error("third step-down rail does not follow pin three");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside read answer");
    a_addr_read: assert property ($past(reg_rd) && $past(reg_addr) == REO_OFS_ADDR |->
        reg_rdata[15:8] == REO_BUS_RD_BYTE && reg_rdata[6:0] == REO_BUS_ADDR)
        else $error("bus address register wrong");
    a_off_rails_low: assert property (power_off |=> !step_down_rail_first
        && !step_down_rail_second && !step_down_rail_third && !linear_rail_first
        && !linear_rail_second && !load_switch_gate)
        else $error("rail on while powered off");
    a_off_needs_press: assert property ($rose(power_off) |->
        !$past(pushbutton_input_n, 4) && !$past(pushbutton_input_n, 5))
        else $error("power off without a held press");
    a_cycle_reset: assert property (since_rst_reg == 3'h0 |-> power_cycle_allowed)
        else $error("power cycle enable not set after reset");
    a_cycle_follow: assert property (reg_wr && reg_addr == REO_OFS_CTRL |=>
        power_cycle_allowed == $past(reg_wdata[REO_CTRL_CYCLE_BIT]))
        else $error("power cycle enable does not follow control write");
endmodule

// File: reo_uproc_model.sv
`timescale 1ns/100ps
// external processor: owns all rail ordering through the group pins
module reo_uproc_model (
    input  wire logic sys_clk,
    output logic [3:0] group_en,   // bit0 = pin one .. bit3 = pin four
    output logic       button_n    // pushbutton, active low
);
    initial begin
        group_en = 4'h0;
        button_n = 1'b1;
    end
    // ordering and timing of rails come only from here, the device adds none
    task automatic set_groups(input logic [3:0] v);
        @(posedge sys_clk);
        group_en <= v;
    endtask
    // hold the button low for a number of cycles, then release
    task automatic hold_button(input int cyc);
        @(posedge sys_clk);
        button_n <= 1'b0;
        repeat (cyc) @(posedge sys_clk);
        button_n <= 1'b1;
    endtask
endmodule

// File: rail_enable_option_logic_bench.sv
`timescale 1ns/100ps
module rail_enable_option_logic_bench;
    import reo_pkg::*;
    typedef struct packed { logic [3:0] addr; logic [31:0] exp; logic [31:0] mask; } reo_note_s;
    logic sys_clk, nrst, reg_wr, reg_rd, rd_seen, power_off, power_cycle_allowed;
    logic [3:0] reg_addr, grp;
    logic [31:0] reg_wdata, reg_rdata;
    logic b1, b2, b3, l1, l2, ls, btn_n;
    reo_note_s notes[$];   // expected read answers, oldest first
    reo_note_s cur;
    int mismatches, checked, seed;
    logic [3:0] v;
    logic [7:0] code;
    reo_uproc_model u_cpu (.sys_clk(sys_clk), .group_en(grp), .button_n(btn_n));
    reo_top #(.LONG_PRESS_CYC(32'h14)) u_dut (
        .sys_clk(sys_clk), .nrst(nrst), .general_pin_one(grp[0]), .general_pin_two(grp[1]),
        .general_pin_three(grp[2]), .general_pin_four(grp[3]), .pushbutton_input_n(btn_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .step_down_rail_first(b1), .step_down_rail_second(b2),
        .step_down_rail_third(b3), .linear_rail_first(l1), .linear_rail_second(l2),
        .load_switch_gate(ls), .power_off(power_off), .power_cycle_allowed(power_cycle_allowed));
    // 25 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    // the read note goes on the queue before the strobe so the watcher finds it
    task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
        notes.push_back('{a, e, m});
        @(posedge sys_clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
    endtask
    // status image: {ls, linear_rail_second, linear_rail_first, b3, b2, b1} from the group pins
    function automatic logic [31:0] status_of(input logic [3:0] p);
        return {26'h0, p[0], p[1], p[1], p[2], p[0], p[3]};
    endfunction
    function automatic logic [31:0] base_of(input bit opt, input int i);
        return (opt && (i == 0 || i == 3)) ? REO_BASE_06_UV : REO_BASE_08_UV;
    endfunction
    function automatic logic [31:0] step_of(input bit opt, input int i);
        return (opt && (i == 0 || i == 3)) ? REO_STEP_9376_UV : REO_STEP_125_UV;
    endfunction
    // watcher: read data stand only in the cycle after the strobe
    always @(posedge sys_clk) begin
        if (rd_seen === 1'b1) begin
            cur = notes.pop_front();
            checked++;
            if (((reg_rdata ^ cur.exp) & cur.mask) !== 32'h0) begin
                mismatches++;
                $display("MISMATCH reg %h expected %h seen %h", cur.addr, cur.exp, reg_rdata);
            end
        end
        rd_seen <= reg_rd;
    end
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // watchdog: the tests need well under a thousand cycles
    initial begin
        #(40 * 20000);
        mismatches++;
        complete_run();
    end
    initial begin
        seed = 32'h02b1;
        nrst = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0;
        reg_addr = 4'h0; reg_wdata = 32'h0; mismatches = 0; checked = 0;
        repeat (4) @(posedge sys_clk);
        nrst <= 1'b1;
        rd(REO_OFS_CTRL, 32'h01, 32'hff);
        rd(REO_OFS_ADDR, 32'h4b25, 32'hff7f);
        rd(4'hf, 32'h0, 32'hffffffff);
        $display("test reset values done");
        for (int o = 0; o < 2; o++) begin
            wr(REO_OFS_CTRL, o ? 32'h04 : 32'h01);
            rd(REO_OFS_CTRL, o ? 32'h04 : 32'h01, 32'hff);
            for (int i = 0; i < 4; i++) begin
                rd(4'(REO_OFS_VBASE_B1 + i), base_of(o, i), '1);
                rd(4'(REO_OFS_VSTEP_B1 + i), step_of(o, i), '1);
            end
            for (int i = 0; i < 4; i++) begin
                code = 8'($random(seed));
                wr(4'(REO_OFS_VCODE_B1 + i), {24'h0, code});
                rd(4'(REO_OFS_VCODE_B1 + i), {24'h0, code}, 32'hff);
            end
        end
        wr(REO_OFS_CTRL, 32'h01);
        $display("test voltage scale done");
        for (int k = 0; k < 10; k++) begin
            v = (k == 0) ? 4'hf : 4'($random(seed));
            u_cpu.set_groups(v);
            repeat (4) @(posedge sys_clk);
            wr(REO_OFS_STATUS, 32'h0);
            rd(REO_OFS_STATUS, status_of(v), 32'h7f);
        end
        $display("test rail pins done");
        u_cpu.set_groups(4'hf);
        u_cpu.hold_button(40);
        repeat (4) @(posedge sys_clk);
        rd(REO_OFS_STATUS, status_of(4'hf), 32'h7f);
        wr(REO_OFS_CTRL, 32'h03);
        u_cpu.hold_button(40);
        repeat (4) @(posedge sys_clk);
        rd(REO_OFS_STATUS, 32'h40, 32'h7f);
        wr(REO_OFS_CTRL, 32'h0b);
        repeat (5) @(posedge sys_clk);
        rd(REO_OFS_STATUS, status_of(4'hf), 32'h7f);
        rd(REO_OFS_CTRL, 32'h03, 32'hff);
        $display("test pushbutton done");
        repeat (3) @(posedge sys_clk);
        complete_run();
    end
endmodule
bind reo_top reo_top_props u_props (
    .sys_clk(sys_clk), .nrst(nrst), .general_pin_one(general_pin_one),
    .general_pin_two(general_pin_two), .general_pin_three(general_pin_three),
    .general_pin_four(general_pin_four), .pushbutton_input_n(pushbutton_input_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .step_down_rail_first(step_down_rail_first),
    .step_down_rail_second(step_down_rail_second), .step_down_rail_third(step_down_rail_third),
    .linear_rail_first(linear_rail_first), .linear_rail_second(linear_rail_second),
    .load_switch_gate(load_switch_gate), .power_off(power_off),
    .power_cycle_allowed(power_cycle_allowed));
